// file: hdl/rfs_pkg.sv
// rfs_pkg: constants shared by the receiver digital assist block
// assumes a single 125 MHz system clock
package rfs_pkg;
  localparam int RFS_FERR_W = 16;
  localparam int RFS_SCALE_W = 12;
  localparam int RFS_SPAN_W = 8;
  localparam int RFS_PKT_W = 8;
  localparam int RFS_SYNC_MAX = 24;
  localparam int RFS_DIV_W = 9;
  localparam int RFS_TONE_W = 8;
  localparam int RFS_DWELL_W = 16;
  localparam int RFS_FRAC_SHIFT = 18;
  // nominal IF 100 kHz expressed as readback value at 1 kHz resolution scale
  localparam logic [15:0] RFS_IF_NOMINAL = 16'h0064;
  localparam int RFS_FINE_STEPS = 10;
  localparam int RFS_COARSE_TIME_US = 200;
  localparam int RFS_CLK_MHZ = 125;
  localparam int RFS_COARSE_CYCLES = RFS_COARSE_TIME_US * RFS_CLK_MHZ;
  localparam logic [1:0] RFS_MODE_PULSE = 2'h0;
  localparam logic [1:0] RFS_MODE_FRAME = 2'h1;
  localparam logic [1:0] RFS_MODE_LOW = 2'h2;
  localparam logic [1:0] RFS_MODE_HIGH = 2'h3;
  localparam logic [15:0] RFS_CENTRE_RESET = 16'h0000;
  typedef enum logic [1:0] {
    RFS_CAL_IDLE = 2'b00,
    RFS_CAL_COARSE = 2'b01,
    RFS_CAL_FINE = 2'b10,
    RFS_CAL_DONE = 2'b11
  } rfs_cal_t;
endpackage

// file: hdl/rfs_sync_det.sv
// rfs_sync_det: sync word correlator with tolerance and packet framing
// assumes rx_bit and rx_bit_en are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module rfs_sync_det #(
  parameter int WMAX = 24
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_mode,
  input wire logic rx_bit,
  input wire logic rx_bit_en,
  input wire logic [WMAX-1:0] sync_word,
  input wire logic [1:0] sync_len_sel,
  input wire logic [1:0] err_tolerance,
  input wire logic [1:0] match_mode,
  input wire logic [7:0] packet_bytes,
  output logic sync_match
);
  import rfs_pkg::*;
  initial begin
    if (WMAX != 24) $error("rfs_sync_det: WMAX must be 24");
  end
  logic [WMAX-1:0] shreg, next_shreg;
  logic hit_pend, next_hit_pend;
  logic framing, next_framing;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] byte_cnt, next_byte_cnt;
  logic next_sync_match;
  logic [4:0] errs;
  logic [WMAX-1:0] diff, mask;

  function automatic logic [WMAX-1:0] len_mask(input logic [1:0] sel);
    logic [WMAX-1:0] m;
    m = '0;
    unique case (sel)
      2'b00: m = 24'h00_0fff;
      2'b01: m = 24'h00_ffff;
      2'b10: m = 24'h0f_ffff;
      2'b11: m = 24'hff_ffff;
    endcase
    return m;
  endfunction

  always_comb begin
    next_shreg = shreg;
    next_hit_pend = 1'b0;
    next_framing = framing;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    mask = len_mask(sync_len_sel); // see R11
    diff = (shreg ^ sync_word) & mask;
    errs = '0;
    for (int i = 0; i < WMAX; i++) begin
      errs = errs + 5'(diff[i]); // see R24
    end
    if (rx_bit_en) begin
      next_shreg = {shreg[WMAX-2:0], rx_bit}; // see R24
      // hit found after previous bit drives pin on this rx clock
      next_hit_pend = rx_mode && (errs <= 5'(err_tolerance)); // see R8 see R13
      if (framing) begin
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          next_byte_cnt = byte_cnt + 8'h01; // see R25
          if (byte_cnt + 8'h01 >= packet_bytes) begin
            next_framing = 1'b0; // see R25
          end
        end
      end
    end
    if (hit_pend && match_mode == RFS_MODE_FRAME && packet_bytes != 8'h00) begin
      next_framing = 1'b1; // see R9
      next_bit_cnt = '0;
      next_byte_cnt = '0;
    end
    if (!rx_mode) begin
      next_framing = 1'b0;
    end
    unique case (match_mode) // see R10
      RFS_MODE_PULSE: next_sync_match = hit_pend;
      RFS_MODE_FRAME: next_sync_match = next_framing;
      RFS_MODE_LOW: next_sync_match = 1'b0;
      RFS_MODE_HIGH: next_sync_match = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shreg <= '0;
      hit_pend <= 1'b0;
      framing <= 1'b0;
      bit_cnt <= '0;
      byte_cnt <= '0;
      sync_match <= 1'b0;
    end else begin
      shreg <= next_shreg;
      hit_pend <= next_hit_pend;
      framing <= next_framing;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      sync_match <= next_sync_match;
    end
  end
endmodule
`default_nettype wire

// file: hdl/rfs_assist.sv
// rfs_assist: frequency loop, sync detector and IF filter calibration sequencer
// assumes config bits are static plain ports from the serial port logic
// Notes on behaviour
// R1 - signed 16-bit frequency error readback
// R2 - zero offset reads nominal IF
// R3 - enabled loop corrects N divider via PI
// R4 - host programs loop scale coefficient
// R5 - correction limited to half span
// R6 - rf halving halves applied span
// R7 - host keeps span below 1.5 filter widths
// R8 - match asserted on next rx clock
// R9 - framing holds match for packet bytes
// R10 - 2-bit field selects match pin behaviour
// R11 - sync length 12, 16, 20 or 24
// R12 - sender sends sync word msb first
// R13 - tolerate zero to three bit errors
// R14 - coarse trigger write starts calibration
// R15 - fine step follows if enabled beforehand
// R16 - host stays off during calibration
// R17 - host sets reference divider for 50 kHz
// R18 - fine step: two tones, ten measurements
// R19 - each tone from own 8-bit divider
// R20 - each step lasts dwell sequencer periods
// R21 - host makes dwell at least 800 us
// R22 - host places tones per filter width
// R23 - calibration done shown on test pin
// R24 - shift bits, count mismatches, compare tolerance
// R25 - count bytes, drop match at length
`timescale 1ns/1ps
`default_nettype none
module rfs_assist #(
  parameter int COARSE_CYCLES = rfs_pkg::RFS_COARSE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [rfs_pkg::RFS_FERR_W-1:0] disc_freq,
  input wire logic disc_valid,
  input wire logic loop_enable,
  input wire logic [rfs_pkg::RFS_SCALE_W-1:0] loop_scale_coefficient,
  input wire logic [rfs_pkg::RFS_SPAN_W-1:0] correction_span,
  input wire logic rf_halving_select,
  input wire logic rx_mode,
  input wire logic rx_bit,
  input wire logic rx_bit_en,
  input wire logic [rfs_pkg::RFS_SYNC_MAX-1:0] sync_word,
  input wire logic [1:0] sync_len_sel,
  input wire logic [1:0] err_tolerance,
  input wire logic [1:0] match_mode,
  input wire logic [rfs_pkg::RFS_PKT_W-1:0] packet_bytes,
  input wire logic cal_write,
  input wire logic coarse_trigger,
  input wire logic fine_enable,
  input wire logic [rfs_pkg::RFS_DIV_W-1:0] cal_ref_divider,
  input wire logic [rfs_pkg::RFS_TONE_W-1:0] lower_tone_div,
  input wire logic [rfs_pkg::RFS_TONE_W-1:0] upper_tone_div,
  input wire logic [rfs_pkg::RFS_DWELL_W-1:0] tone_step_dwell,
  input wire logic [7:0] rssi_level,
  input wire logic test_mux_sel,
  output logic [rfs_pkg::RFS_FERR_W-1:0] freq_error_readback,
  output logic [rfs_pkg::RFS_FERR_W-1:0] n_div_correction,
  output logic sync_match,
  output logic cal_busy,
  output logic tone_sel_upper,
  output logic [rfs_pkg::RFS_TONE_W-1:0] tone_divider,
  output logic [5:0] filter_adjust,
  output logic test_mux_pin
);
  import rfs_pkg::*;
  initial begin
    if (COARSE_CYCLES < 1) $error("rfs_assist: COARSE_CYCLES must be positive");
  end

  // frequency loop
  logic signed [15:0] integ, next_integ;
  logic signed [15:0] corr, next_corr;
  logic [15:0] next_readback;
  logic signed [16:0] err_s;
  logic signed [29:0] prop;
  logic signed [15:0] lim;
  logic signed [17:0] raw;

  always_comb begin
    next_readback = freq_error_readback;
    next_integ = integ;
    next_corr = corr;
    err_s = '0;
    prop = '0;
    raw = '0;
    // half span, halved again when rf halving is on
    lim = rf_halving_select ? 16'(correction_span >> 2) : 16'(correction_span >> 1); // see R5 see R6
    if (disc_valid) begin
      next_readback = disc_freq; // see R1 see R2
      if (loop_enable) begin
        // error relative to nominal IF
        err_s = 17'(signed'({1'b0, disc_freq})) - 17'(signed'({1'b0, RFS_IF_NOMINAL}));
        prop = 30'(err_s) * 30'(signed'({1'b0, loop_scale_coefficient}));
        next_integ = 16'(integ - 16'(prop >>> 18)); // see R3
        raw = 18'(next_integ) - 18'(prop >>> 16);
        if (raw > 18'(lim)) next_corr = lim; // see R5
        else if (raw < -18'(lim)) next_corr = -lim;
        else next_corr = 16'(raw);
        if (next_integ > lim) next_integ = lim;
        else if (next_integ < -lim) next_integ = -lim;
      end
    end
    if (!loop_enable) begin
      next_integ = '0;
      next_corr = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      freq_error_readback <= '0;
      integ <= '0;
      corr <= '0;
    end else begin
      freq_error_readback <= next_readback;
      integ <= next_integ;
      corr <= next_corr;
    end
  end
  assign n_div_correction = corr;

  rfs_sync_det #(.WMAX(RFS_SYNC_MAX)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .rx_mode(rx_mode),
    .rx_bit(rx_bit),
    .rx_bit_en(rx_bit_en),
    .sync_word(sync_word),
    .sync_len_sel(sync_len_sel),
    .err_tolerance(err_tolerance),
    .match_mode(match_mode),
    .packet_bytes(packet_bytes),
    .sync_match(sync_match)
  );

  // calibration sequencer; fine-step clock is an enable from cal_ref_divider, coarse step counts sys_clk cycles
  rfs_cal_t st, next_st;
  logic [8:0] seq_div, next_seq_div;
  logic [23:0] tcnt, next_tcnt;
  logic [3:0] steps, next_steps;
  logic upper, next_upper;
  logic [7:0] rssi_low, next_rssi_low;
  logic [5:0] adj, next_adj;
  logic [7:0] next_tone;
  logic seq_en;

  always_comb begin
    next_st = st;
    next_tcnt = tcnt;
    next_steps = steps;
    next_upper = upper;
    next_rssi_low = rssi_low;
    next_adj = adj;
    seq_en = (seq_div == 9'h000);
    next_seq_div = seq_en ? cal_ref_divider - 9'h001 : seq_div - 9'h001;
    unique case (st)
      RFS_CAL_IDLE, RFS_CAL_DONE: begin
        if (cal_write && coarse_trigger) begin
          next_st = RFS_CAL_COARSE; // see R14
          next_tcnt = '0;
        end
      end
      RFS_CAL_COARSE: begin
        next_tcnt = tcnt + 24'h00_0001;
        if (tcnt >= 24'(COARSE_CYCLES - 1)) begin
          next_tcnt = '0;
          next_steps = '0;
          next_upper = 1'b0;
          next_st = fine_enable ? RFS_CAL_FINE : RFS_CAL_DONE; // see R15
        end
      end
      RFS_CAL_FINE: begin
        if (seq_en) begin
          next_tcnt = tcnt + 24'h00_0001;
          // each half step measures one tone; two halves make one dwell
          if (tcnt[15:0] + 16'h0001 >= (tone_step_dwell >> 1) || tone_step_dwell < 16'h0002) begin
            next_tcnt = '0;
            next_upper = !upper; // see R18
            if (!upper) begin
              next_rssi_low = rssi_level;
            end else begin
              // lower attenuated more: move centre down
              if (rssi_low < rssi_level && adj != 6'h00) next_adj = adj - 6'h01;
              else if (rssi_low > rssi_level && adj != 6'h3f) next_adj = adj + 6'h01;
              next_steps = steps + 4'h1; // see R20
              if (steps == 4'(RFS_FINE_STEPS - 1)) next_st = RFS_CAL_DONE; // see R18
            end
          end
        end
      end
    endcase
    next_tone = next_upper ? upper_tone_div : lower_tone_div; // see R19
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= RFS_CAL_IDLE;
      seq_div <= '0;
      tcnt <= '0;
      steps <= '0;
      upper <= 1'b0;
      rssi_low <= '0;
      adj <= 6'h20;
      cal_busy <= 1'b0;
      tone_sel_upper <= 1'b0;
      tone_divider <= '0;
      filter_adjust <= 6'h20;
      test_mux_pin <= 1'b0;
    end else begin
      st <= next_st;
      seq_div <= next_seq_div;
      tcnt <= next_tcnt;
      steps <= next_steps;
      upper <= next_upper;
      rssi_low <= next_rssi_low;
      adj <= next_adj;
      cal_busy <= (next_st == RFS_CAL_COARSE) || (next_st == RFS_CAL_FINE);
      tone_sel_upper <= next_upper;
      tone_divider <= next_tone;
      filter_adjust <= next_adj;
      test_mux_pin <= test_mux_sel ? (next_st == RFS_CAL_DONE) : sync_match; // see R23
    end
  end
endmodule
`default_nettype wire

// file: testbench/rfs_assist_properties.sv
// rfs_assist_properties: port-level checks of the receiver assist block
// assumes one sys_clk domain and a synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module rfs_assist_properties
  import rfs_pkg::*;
#(
  parameter int COARSE_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] disc_freq,
  input wire logic disc_valid,
  input wire logic loop_enable,
  input wire logic [7:0] correction_span,
  input wire logic rf_halving_select,
  input wire logic [1:0] match_mode,
  input wire logic cal_write,
  input wire logic coarse_trigger,
  input wire logic fine_enable,
  input wire logic [15:0] freq_error_readback,
  input wire logic [15:0] n_div_correction,
  input wire logic sync_match,
  input wire logic cal_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  int lim;
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  always_comb lim = rf_halving_select ? int'(correction_span) / 4 : int'(correction_span) / 2;
  always_comb next_busy_cnt = (rst || !cal_busy) ? 16'h0000 : busy_cnt + 16'h0001;
  always_ff @(posedge sys_clk) busy_cnt <= next_busy_cnt;
  sequence s_start;
    cal_write && coarse_trigger && !cal_busy;
  endsequence
  sequence s_pulse_rise;
    (match_mode == RFS_MODE_PULSE)[*3] ##0 $rose(sync_match);
  endsequence
  AST_RB_LOAD: assert property (disc_valid |=> freq_error_readback == $past(disc_freq))
    else $error("readback not loaded");
  AST_RB_HOLD: assert property (!disc_valid |=> $stable(freq_error_readback))
    else $error("readback moved without new estimate");
  AST_LOOP_OFF: assert property (!loop_enable |=> n_div_correction == 16'h0000)
    else $error("correction present with loop off");
  AST_LIMIT: assert property (loop_enable |-> $signed(n_div_correction) <= lim && $signed(n_div_correction) >= -lim)
    else $error("correction outside span");
  AST_CAL_START: assert property (s_start |=> cal_busy)
    else $error("calibration did not start");
  AST_COARSE_LEN: assert property (cal_busy && !fine_enable |-> busy_cnt < COARSE_CYCLES + 2)
    else $error("coarse calibration too long");
  AST_FORCE_LOW: assert property ((match_mode == RFS_MODE_LOW)[*3] |-> !sync_match)
    else $error("match pin not held low");
  AST_FORCE_HIGH: assert property ((match_mode == RFS_MODE_HIGH)[*3] |-> sync_match)
    else $error("match pin not held high");
  AST_PULSE: assert property (s_pulse_rise |=> !sync_match)
    else $error("match pulse wider than one cycle");
endmodule
bind rfs_assist rfs_assist_properties #(.COARSE_CYCLES(COARSE_CYCLES)) u_props (.sys_clk, .rst,
  .disc_freq, .disc_valid, .loop_enable, .correction_span, .rf_halving_select, .match_mode,
  .cal_write, .coarse_trigger, .fine_enable, .freq_error_readback, .n_div_correction,
  .sync_match, .cal_busy);
`default_nettype wire

// file: testbench/rfs_host_tx.sv
// rfs_host_tx: far-end bit source feeding the sync detector
// assumes bits are taken on sys_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module rfs_host_tx (
  input wire logic sys_clk,
  output logic rx_bit,
  output logic rx_bit_en
);
  bit sending = 1'b0;
  initial begin
    rx_bit = 1'b0;
    rx_bit_en = 1'b0;
  end
  // idle line toggles so a stale bit is never trusted
  always @(posedge sys_clk) if (!sending) rx_bit <= #1 ~rx_bit;
  task automatic send(input logic [23:0] w, input int n);
    sending = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk) #1;
      rx_bit = w[i];
      rx_bit_en = 1'b1;
    end
    // one trailing strobe: the detector judges a word on the strobe after it
    @(posedge sys_clk) #1;
    rx_bit = ~rx_bit;
    @(posedge sys_clk) #1;
    rx_bit_en = 1'b0;
    sending = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// testbench: self-checking bench for the receiver assist block
// assumes the design files and the property checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rfs_pkg::*;
  localparam int CC = 20;
  logic sys_clk = 1'b0, rst = 1'b1, disc_valid = 1'b0, loop_enable = 1'b0;
  logic rf_halving_select = 1'b0, rx_mode = 1'b1, cal_write = 1'b0, coarse_trigger = 1'b0;
  logic fine_enable = 1'b0, test_mux_sel = 1'b0, seen = 1'b0;
  logic [15:0] disc_freq = 16'h0000, tone_step_dwell = 16'h0002;
  logic [11:0] loop_scale_coefficient = 12'h0100;
  logic [7:0] correction_span = 8'h10, packet_bytes = 8'h00, rssi_level = 8'h40;
  logic [7:0] lower_tone_div = 8'h20, upper_tone_div = 8'h30;
  logic [23:0] sync_word = 24'hA5_C396;
  logic [8:0] cal_ref_divider = 9'h001;
  logic [1:0] sync_len_sel = 2'h3, err_tolerance = 2'h0, match_mode = 2'h0;
  logic [15:0] freq_error_readback, n_div_correction;
  logic [7:0] tone_divider;
  logic [5:0] filter_adjust;
  logic rx_bit, rx_bit_en, sync_match, cal_busy, tone_sel_upper, test_mux_pin;
  int err_count = 0, checks = 0, cyc = 0;
  rfs_host_tx partner (.sys_clk, .rx_bit, .rx_bit_en);
  rfs_assist #(.COARSE_CYCLES(CC)) dut (.sys_clk, .rst, .disc_freq, .disc_valid, .loop_enable,
    .loop_scale_coefficient, .correction_span, .rf_halving_select, .rx_mode, .rx_bit, .rx_bit_en,
    .sync_word, .sync_len_sel, .err_tolerance, .match_mode, .packet_bytes, .cal_write,
    .coarse_trigger, .fine_enable, .cal_ref_divider, .lower_tone_div, .upper_tone_div,
    .tone_step_dwell, .rssi_level, .test_mux_sel, .freq_error_readback, .n_div_correction,
    .sync_match, .cal_busy, .tone_sel_upper, .tone_divider, .filter_adjust, .test_mux_pin);
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sync_match) seen <= 1'b1;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic estimates(input logic [15:0] v, input int n);
    repeat (n) begin
      disc_freq = v;
      disc_valid = 1'b1;
      tick(1);
      disc_valid = 1'b0;
      tick(2);
    end
  endtask
  task automatic t_readback();
    estimates(RFS_IF_NOMINAL, 1);
    chk(freq_error_readback, RFS_IF_NOMINAL);
    estimates(16'h8123, 1);
    chk(freq_error_readback, 16'h8123);
  endtask
  task automatic t_loop(input logic half, input int lim);
    chk(n_div_correction, 16'h0000);
    rf_halving_select = half;
    loop_enable = 1'b1;
    estimates(16'h7000, 60);
    chk(16'($signed(n_div_correction) <= lim && $signed(n_div_correction) >= -lim), 16'h0001);
    chk(16'(n_div_correction != 16'h0000), 16'h0001);
    loop_enable = 1'b0;
    tick(2);
  endtask
  task automatic t_sync(input logic [1:0] len, input logic [1:0] tol, input int errs, input logic exp);
    sync_len_sel = len;
    err_tolerance = tol;
    seen = 1'b0;
    partner.send(sync_word ^ 24'((1 << errs) - 1), 12 + 4 * len);
    tick(4);
    chk(16'(seen), 16'(exp));
  endtask
  task automatic t_frame();
    match_mode = RFS_MODE_FRAME;
    packet_bytes = 8'h01;
    t_sync(2'h3, 2'h0, 0, 1'b1);
    chk(16'(sync_match), 16'h0001);
    chk(16'(test_mux_pin), 16'h0001);
    partner.send(24'h00_0000, 8);
    tick(3);
    chk(16'(sync_match), 16'h0000);
    chk(16'(test_mux_pin), 16'h0000);
    match_mode = RFS_MODE_LOW;
    t_sync(2'h3, 2'h0, 0, 1'b0);
    match_mode = RFS_MODE_HIGH;
    tick(4);
    chk(16'(sync_match), 16'h0001);
    match_mode = RFS_MODE_PULSE;
    tick(2);
  endtask
  task automatic t_cal(input logic fine, input int lo, input int hi);
    int n;
    int ups;
    n = 0;
    ups = 0;
    fine_enable = fine;
    test_mux_sel = 1'b1;
    rssi_level = 8'h40;
    tick(1);
    cal_write = 1'b1;
    coarse_trigger = 1'b1;
    tick(1);
    cal_write = 1'b0;
    coarse_trigger = 1'b0;
    chk(16'(cal_busy), 16'h0001);
    chk(16'(tone_divider), 16'(lower_tone_div));
    while (cal_busy === 1'b1 && n < 5000) begin
      n++;
      // upper tone reads weaker, so each step should move the centre up
      rssi_level = (tone_sel_upper === 1'b1) ? 8'h30 : 8'h40;
      if (tone_sel_upper === 1'b1) begin
        ups++;
        chk(16'(tone_divider), 16'(upper_tone_div));
      end
      tick(1);
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
    chk(16'(ups), fine ? 16'h000a : 16'h0000);
    chk(16'(filter_adjust), fine ? 16'h002a : 16'h0020);
    tick(1);
    chk(16'(test_mux_pin), 16'h0001);
    test_mux_sel = 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    tick(3);
    rst = 1'b0;
    tick(1);
    t_readback();
    t_loop(1'b0, 8);
    t_loop(1'b1, 4);
    for (int l = 0; l < 4; l++) t_sync(2'(l), 2'h0, 0, 1'b1);
    for (int t = 0; t < 4; t++) begin
      t_sync(2'h3, 2'(t), t, 1'b1);
      t_sync(2'h3, 2'(t), t + 1, 1'b0);
    end
    t_frame();
    t_cal(1'b0, CC - 1, CC + 1);
    t_cal(1'b1, CC + 20, 4000);
    test_done;
  end
endmodule
`default_nettype wire
